// file: verilog/mil_pkg.sv
/*
  Package for the interrupt gathering block: register offsets, bit positions,
  reset values, vector address and latency figures.
  Assumes a 32-bit AXI4-Lite register bus and an 8-bit core.
*/
package mil_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CONTROL   = 8'h00;
  localparam logic [7:0] OFS_PFLAG_A   = 8'h04;
  localparam logic [7:0] OFS_PFLAG_B   = 8'h08;
  localparam logic [7:0] OFS_PEN_A     = 8'h0c;
  localparam logic [7:0] OFS_PEN_B     = 8'h10;
  localparam logic [7:0] OFS_OPTION    = 8'h14;
  localparam logic [7:0] OFS_EVT_STAT  = 8'h18;
  localparam logic [7:0] OFS_EVT_MASK  = 8'h1c;
  localparam logic [7:0] OFS_CORE_STAT = 8'h20;
  // Control and option register fields
  localparam int BIT_GIE  = 7;
  localparam int BIT_PERIPH_GROUP_ENABLE = 6;
  localparam int BIT_TIMER_ZERO_IRQ_ENABLE = 5;
  localparam int BIT_EDGE_IRQ_ENABLE = 4;
  localparam int BIT_PORT_CHANGE_IRQ_ENABLE = 3;
  localparam int BIT_TIMER_ZERO_FLAG = 2;
  localparam int BIT_EDGE_IRQ_FLAG = 1;
  localparam int BIT_PORT_CHANGE_FLAG = 0;
  localparam int BIT_EDGE = 6;
  // Reset values
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [7:0] RST_PERIPH  = 8'h00;
  localparam logic [7:0] RST_OPTION  = 8'hff;
  // Vector and latency
  localparam logic [12:0] IRQ_VECTOR     = 13'h0004;
  localparam int          LAT_MIN_CYCLES = 3;
  localparam logic [1:0]  AXI_OKAY       = 2'b00;
  localparam logic [1:0]  AXI_SLVERR     = 2'b10;
  // Event status bits
  localparam int EV_TAKEN = 0;
  localparam int EV_WAKE  = 1;
  localparam int EV_RET   = 2;
  localparam int EV_NUM   = 3;
  typedef enum logic [1:0] {ST_RUN, ST_SLEEP, ST_POSTWAKE, ST_PEND} mil_state_t;
endpackage

// file: verilog/mil_edge_det.sv
/*
  Edge and change detector for the external edge pin and port change nibble.
  Inputs are synchronous to CLK.
*/
`timescale 1ns/1ps
`default_nettype none
module mil_edge_det
  import mil_pkg::*;
#(
  parameter int W = 1
)(
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] din,
  input  wire logic         rising,
  output logic              edge_hit,
  output logic              change_hit
);
  logic [W-1:0] prev_q;
  logic [W-1:0] prev_d;
  logic         seen_q;
  logic         seen_d;

  always_comb
  begin
    prev_d = din;
    seen_d = 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      prev_q <= '0;
      seen_q <= 1'b0;
    end
    else
    begin
      prev_q <= prev_d;
      seen_q <= seen_d;
    end
  end

  // First sample after reset only primes the history, no false edge
  assign change_hit = seen_q && (din != prev_q);
  assign edge_hit   = seen_q && (rising ? (din[0] && !prev_q[0]) : (!din[0] && prev_q[0]));
endmodule
`default_nettype wire

// file: verilog/mil_lat_pipe.sv
/*
  Short delay line that stretches a request into the fixed vector latency.
  Assumes a one-cycle request pulse from the caller.
*/
`timescale 1ns/1ps
`default_nettype none
module mil_lat_pipe
  import mil_pkg::*;
#(
  parameter int DEPTH = LAT_MIN_CYCLES
)(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic flush,
  input  wire logic din,
  output logic      dout
);
  logic [DEPTH-1:0] sr_q;
  logic [DEPTH-1:0] sr_d;

  always_comb
  begin
    if (flush)
      sr_d = '0;
    else
      sr_d = {sr_q[DEPTH-2:0], din};
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      sr_q <= '0;
    else
      sr_q <= sr_d;
  end

  // Any event still in the line blocks a take, not just the oldest one
  assign dout = |sr_q;
endmodule
`default_nettype wire

// file: verilog/mil_irq_logic.sv
/*
  Interrupt gathering and vectoring logic of an 8-bit core, with AXI4-Lite
  register access, sleep wake-up and an event interrupt output.
  Assumes sources give one-cycle pulses and the core sequencer honours
  the take and wake outputs and signals instruction boundaries.
*/
// Notes on behaviour
// - Nineteen sources, each with flag and enable
// - Flags set regardless of any enable
// - Global enable at bit 7 gates all
// - Enabled pending request vectors at an instruction boundary
// - Reset clears global enable
// - Return instruction pops and sets global enable
// - Accept clears enable, pushes, vectors 0004h
// - Peripheral flags gated by group enable
// - External event to vector three or four cycles
// - Edge pin polarity from option bit 6
// - Edge sets bit 1, enabled by bit 4
// - Enabled edge wakes from sleep
// - Timer rollover sets bit 2, enable bit 5
// - Port nibble change sets bit 0
// - Only return address saved by hardware
// - Wake leaves the waking flag set
// - After wake, next instruction then vector
`timescale 1ns/1ps
`default_nettype none
module mil_irq_logic
  import mil_pkg::*;
#(
  parameter int PC_W = 13
)(
  // Clock and reset
  input  wire logic            CLK,
  input  wire logic            RST,
  // Interrupt sources
  input  wire logic            EDGE_IRQ_PIN,
  input  wire logic [3:0]      SECOND_PORT_PINS,
  input  wire logic            TIMER_ZERO_ROLLOVER,
  input  wire logic [7:0]      PERIPH_EVT_A,
  input  wire logic [7:0]      PERIPH_EVT_B,
  // Core sequencer
  input  wire logic            INSTR_BOUNDARY,
  input  wire logic            SLEEP_INSTR,
  input  wire logic            RETURN_FROM_IRQ_INSTR,
  input  wire logic [PC_W-1:0] RETURN_PC,
  output logic                 IRQ_TAKE,
  output logic                 STACK_PUSH,
  output logic                 STACK_POP,
  output logic [PC_W-1:0]      PUSH_PC,
  output logic [PC_W-1:0]      VECTOR_PC,
  output logic                 CORE_WAKE,
  output logic                 CORE_ASLEEP,
  // AXI4-Lite slave
  input  wire logic [7:0]      S_AXI_AWADDR,
  input  wire logic            S_AXI_AWVALID,
  output logic                 S_AXI_AWREADY,
  input  wire logic [31:0]     S_AXI_WDATA,
  input  wire logic [3:0]      S_AXI_WSTRB,
  input  wire logic            S_AXI_WVALID,
  output logic                 S_AXI_WREADY,
  output logic [1:0]           S_AXI_BRESP,
  output logic                 S_AXI_BVALID,
  input  wire logic            S_AXI_BREADY,
  input  wire logic [7:0]      S_AXI_ARADDR,
  input  wire logic            S_AXI_ARVALID,
  output logic                 S_AXI_ARREADY,
  output logic [31:0]          S_AXI_RDATA,
  output logic [1:0]           S_AXI_RRESP,
  output logic                 S_AXI_RVALID,
  input  wire logic            S_AXI_RREADY,
  // Event interrupt
  output logic                 IRQ_OUT
);
  logic [7:0]        ctl_q, ctl_d;
  logic [7:0]        pfa_q, pfa_d, pfb_q, pfb_d;
  logic [7:0]        pea_q, pea_d, peb_q, peb_d;
  logic [7:0]        opt_q, opt_d;
  logic [EV_NUM-1:0] evs_q, evs_d, evm_q, evm_d;
  mil_state_t        st_q, st_d;
  logic [PC_W-1:0]   push_q, push_d;
  logic              take_q, take_d;
  logic              aw_q, aw_d, w_q, w_d, b_q, b_d, r_q, r_d;
  logic [7:0]        awa_q, awa_d, ara_q, ara_d;
  logic [31:0]       wd_q, wd_d, rd_q, rd_d;
  logic [3:0]        ws_q, ws_d;
  logic [1:0]        bresp_q, bresp_d, rresp_q, rresp_d;
  logic              edge_hit, rb_hit, unused_chg, unused_edge;
  logic              pend, wake_src, do_take, wr_fire, ext_evt, ext_late;

  mil_edge_det #(.W(1)) u_edge (
    .clk        (CLK),
    .rst        (RST),
    .din        (EDGE_IRQ_PIN),
    .rising     (opt_q[BIT_EDGE]),
    .edge_hit   (edge_hit),
    .change_hit (unused_chg)
  );

  mil_edge_det #(.W(4)) u_port (
    .clk        (CLK),
    .rst        (RST),
    .din        (SECOND_PORT_PINS),
    .rising     (1'b1),
    .edge_hit   (unused_edge),
    .change_hit (rb_hit)
  );

  // External events are held back so vectoring lands three to four cycles on
  assign ext_evt = edge_hit | rb_hit;
  // The flag register itself supplies the first cycle of the latency
  mil_lat_pipe #(.DEPTH(LAT_MIN_CYCLES - 1)) u_lat (
    .clk   (CLK),
    .rst   (RST),
    .flush (1'b0),
    .din   (ext_evt),
    .dout  (ext_late)
  );

  // Pending: own flag and enable, peripherals also need group enable
  always_comb
  begin
    wake_src = (ctl_q[BIT_EDGE_IRQ_FLAG] & ctl_q[BIT_EDGE_IRQ_ENABLE])
             | (ctl_q[BIT_TIMER_ZERO_FLAG] & ctl_q[BIT_TIMER_ZERO_IRQ_ENABLE])
             | (ctl_q[BIT_PORT_CHANGE_FLAG] & ctl_q[BIT_PORT_CHANGE_IRQ_ENABLE])
             | (ctl_q[BIT_PERIPH_GROUP_ENABLE] & |((pfa_q & pea_q) | (pfb_q & peb_q)));
    pend = ctl_q[BIT_GIE] & wake_src;
  end

  assign wr_fire = aw_q & w_q & ~b_q;

  // Sequencer: sleep, wake and take
  always_comb
  begin
    st_d    = st_q;
    do_take = 1'b0;
    unique case (st_q)
      ST_RUN:
      begin
        // A pending request before sleep turns sleep into a no-op
        if (SLEEP_INSTR && !wake_src)
          st_d = ST_SLEEP;
        else if (pend && INSTR_BOUNDARY && !ext_late)
          do_take = 1'b1;
      end
      ST_SLEEP:
        if (wake_src)
          st_d = ST_POSTWAKE;
      ST_POSTWAKE:
        if (INSTR_BOUNDARY)
          st_d = ST_PEND;
      ST_PEND:
      begin
        st_d = ST_RUN;
        do_take = pend;
      end
    endcase
  end

  // Control and flag registers
  always_comb
  begin
    ctl_d = ctl_q;
    pfa_d = pfa_q;
    pfb_d = pfb_q;
    pea_d = pea_q;
    peb_d = peb_q;
    opt_d = opt_q;
    evs_d = evs_q;
    evm_d = evm_q;
    // Software writes land first so hardware sets below win the same cycle
    if (wr_fire && ws_q[0])
    begin
      unique case (awa_q)
        OFS_CONTROL:  ctl_d = wd_q[7:0];
        OFS_PFLAG_A:  pfa_d = wd_q[7:0];
        OFS_PFLAG_B:  pfb_d = wd_q[7:0];
        OFS_PEN_A:    pea_d = wd_q[7:0];
        OFS_PEN_B:    peb_d = wd_q[7:0];
        OFS_OPTION:   opt_d = wd_q[7:0];
        OFS_EVT_STAT: evs_d = evs_q & ~wd_q[EV_NUM-1:0];
        OFS_EVT_MASK: evm_d = wd_q[EV_NUM-1:0];
        default:      ;
      endcase
    end
    if (edge_hit)
      ctl_d[BIT_EDGE_IRQ_FLAG] = 1'b1;
    if (TIMER_ZERO_ROLLOVER)
      ctl_d[BIT_TIMER_ZERO_FLAG] = 1'b1;
    if (rb_hit)
      ctl_d[BIT_PORT_CHANGE_FLAG] = 1'b1;
    pfa_d = pfa_d | PERIPH_EVT_A;
    pfb_d = pfb_d | PERIPH_EVT_B;
    if (do_take)
    begin
      ctl_d[BIT_GIE] = 1'b0;
      evs_d[EV_TAKEN] = 1'b1;
    end
    if (RETURN_FROM_IRQ_INSTR)
    begin
      ctl_d[BIT_GIE] = 1'b1;
      evs_d[EV_RET] = 1'b1;
    end
    if (st_q == ST_SLEEP && wake_src)
      evs_d[EV_WAKE] = 1'b1;
  end

  // Only the return address is captured, nothing else of the core
  always_comb
  begin
    push_d = do_take ? RETURN_PC : push_q;
    take_d = do_take;
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      ctl_q  <= RST_CONTROL;
      pfa_q  <= RST_PERIPH;
      pfb_q  <= RST_PERIPH;
      pea_q  <= RST_PERIPH;
      peb_q  <= RST_PERIPH;
      opt_q  <= RST_OPTION;
      evs_q  <= '0;
      evm_q  <= '0;
      st_q   <= ST_RUN;
      push_q <= '0;
      take_q <= 1'b0;
    end
    else
    begin
      ctl_q  <= ctl_d;
      pfa_q  <= pfa_d;
      pfb_q  <= pfb_d;
      pea_q  <= pea_d;
      peb_q  <= peb_d;
      opt_q  <= opt_d;
      evs_q  <= evs_d;
      evm_q  <= evm_d;
      st_q   <= st_d;
      push_q <= push_d;
      take_q <= take_d;
    end
  end

  assign IRQ_TAKE    = take_q;
  assign STACK_PUSH  = take_q;
  assign STACK_POP   = RETURN_FROM_IRQ_INSTR;
  assign PUSH_PC     = push_q;
  assign VECTOR_PC   = IRQ_VECTOR;
  assign CORE_WAKE   = (st_q == ST_SLEEP) && wake_src;
  assign CORE_ASLEEP = (st_q == ST_SLEEP);
  assign IRQ_OUT     = |(evs_q & evm_q);

  // AXI4-Lite slave: address and data taken in either order
  always_comb
  begin
    aw_d    = aw_q;
    w_d     = w_q;
    b_d     = b_q;
    awa_d   = awa_q;
    wd_d    = wd_q;
    ws_d    = ws_q;
    bresp_d = bresp_q;
    if (S_AXI_AWVALID && !aw_q)
    begin
      aw_d  = 1'b1;
      awa_d = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && !w_q)
    begin
      w_d  = 1'b1;
      wd_d = S_AXI_WDATA;
      ws_d = S_AXI_WSTRB;
    end
    if (wr_fire)
    begin
      b_d = 1'b1;
      bresp_d = (awa_q <= OFS_EVT_MASK && awa_q[1:0] == 2'b00) ? AXI_OKAY : AXI_SLVERR;
    end
    if (b_q && S_AXI_BREADY)
    begin
      b_d  = 1'b0;
      aw_d = 1'b0;
      w_d  = 1'b0;
    end
  end

  always_comb
  begin
    r_d     = r_q;
    ara_d   = ara_q;
    rd_d    = rd_q;
    rresp_d = rresp_q;
    if (S_AXI_ARVALID && !r_q)
    begin
      r_d     = 1'b1;
      ara_d   = S_AXI_ARADDR;
      rresp_d = AXI_OKAY;
      unique case (S_AXI_ARADDR)
        OFS_CONTROL:   rd_d = {24'h000000, ctl_q};
        OFS_PFLAG_A:   rd_d = {24'h000000, pfa_q};
        OFS_PFLAG_B:   rd_d = {24'h000000, pfb_q};
        OFS_PEN_A:     rd_d = {24'h000000, pea_q};
        OFS_PEN_B:     rd_d = {24'h000000, peb_q};
        OFS_OPTION:    rd_d = {24'h000000, opt_q};
        OFS_EVT_STAT:  rd_d = {29'h0, evs_q};
        OFS_EVT_MASK:  rd_d = {29'h0, evm_q};
        OFS_CORE_STAT: rd_d = {30'h0, pend, st_q == ST_SLEEP};
        default:
        begin
          rd_d    = 32'h00000000;
          rresp_d = AXI_SLVERR;
        end
      endcase
    end
    else if (r_q && S_AXI_RREADY)
      r_d = 1'b0;
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      aw_q    <= 1'b0;
      w_q     <= 1'b0;
      b_q     <= 1'b0;
      r_q     <= 1'b0;
      awa_q   <= '0;
      ara_q   <= '0;
      wd_q    <= '0;
      rd_q    <= '0;
      ws_q    <= '0;
      bresp_q <= AXI_OKAY;
      rresp_q <= AXI_OKAY;
    end
    else
    begin
      aw_q    <= aw_d;
      w_q     <= w_d;
      b_q     <= b_d;
      r_q     <= r_d;
      awa_q   <= awa_d;
      ara_q   <= ara_d;
      wd_q    <= wd_d;
      rd_q    <= rd_d;
      ws_q    <= ws_d;
      bresp_q <= bresp_d;
      rresp_q <= rresp_d;
    end
  end

  assign S_AXI_AWREADY = ~aw_q;
  assign S_AXI_WREADY  = ~w_q;
  assign S_AXI_BVALID  = b_q;
  assign S_AXI_BRESP   = bresp_q;
  assign S_AXI_ARREADY = ~r_q;
  assign S_AXI_RVALID  = r_q;
  assign S_AXI_RDATA   = rd_q;
  assign S_AXI_RRESP   = rresp_q;
endmodule
`default_nettype wire

// file: tb/mil_core_model.sv
/* Core sequencer model facing the interrupt block.
   Bench gives sleep and return commands as one-cycle pulses. */
`timescale 1ns/1ps
`default_nettype none
module mil_core_model
  import mil_pkg::*;
(
  // Clock, reset and bench commands
  input  wire logic   clk,
  input  wire logic   rst,
  input  wire logic   do_sleep,
  input  wire logic   do_ret,
  // Interrupt block side
  input  wire logic   take,
  input  wire logic   asleep,
  output logic        boundary,
  output logic        sleep_instr,
  output logic        ret_instr,
  output logic [12:0] ret_pc
);
  logic [12:0] pc_q;
  logic        slow_q;
  // Two-cycle instructions leave gaps, so take timing is not regular
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pc_q   <= 13'h0100;
      slow_q <= 1'b0;
    end
    else
    begin
      slow_q <= boundary && pc_q[1:0] == 2'b11;
      if (take)
        pc_q <= IRQ_VECTOR;
      else if (boundary)
        pc_q <= pc_q + 13'h0001;
    end
  end
  assign boundary    = !slow_q && !asleep;
  assign sleep_instr = do_sleep;
  assign ret_instr   = do_ret;
  assign ret_pc      = pc_q;
endmodule
`default_nettype wire

// file: tb/mil_irq_asserts.sv
/* Port checker for the interrupt block.
   Bound to every instance; one clock domain. */
`timescale 1ns/1ps
`default_nettype none
module mil_irq_asserts
  import mil_pkg::*;
#(
  parameter int PC_W = 13
)(
  // Watched ports
  input wire logic            CLK,
  input wire logic            RST,
  input wire logic            SLEEP_INSTR,
  input wire logic            RETURN_FROM_IRQ_INSTR,
  input wire logic [PC_W-1:0] RETURN_PC,
  input wire logic            IRQ_TAKE,
  input wire logic            STACK_PUSH,
  input wire logic            STACK_POP,
  input wire logic [PC_W-1:0] PUSH_PC,
  input wire logic [PC_W-1:0] VECTOR_PC,
  input wire logic            CORE_WAKE,
  input wire logic            CORE_ASLEEP,
  input wire logic            S_AXI_WVALID,
  input wire logic            S_AXI_ARVALID,
  input wire logic            S_AXI_ARREADY,
  input wire logic            S_AXI_RVALID
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  // Nothing can re-arm the enable in these cycles
  sequence s_taken;
    IRQ_TAKE ##1 (!RETURN_FROM_IRQ_INSTR && !S_AXI_WVALID) [*3];
  endsequence
  a_take_pulse: assert property (IRQ_TAKE |=> !IRQ_TAKE) else $error("take held");
  a_take_vector: assert property (IRQ_TAKE |-> STACK_PUSH && VECTOR_PC == 13'h0004)
    else $error("bad vector");
  a_push_addr: assert property (IRQ_TAKE |-> PUSH_PC == $past(RETURN_PC))
    else $error("bad push");
  a_pop_return: assert property (RETURN_FROM_IRQ_INSTR |-> STACK_POP) else $error("no pop");
  a_wake_sleep: assert property (CORE_WAKE |=> !CORE_ASLEEP) else $error("bad wake");
  a_sleep_entry: assert property ($rose(CORE_ASLEEP) |-> $past(SLEEP_INSTR))
    else $error("bad sleep");
  a_gie_cleared: assert property (s_taken |-> !IRQ_TAKE) else $error("retaken");
  a_reset_idle: assert property (disable iff (1'b0) RST |=> !IRQ_TAKE && !CORE_ASLEEP)
    else $error("reset");
  a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("no read answer");
endmodule
bind mil_irq_logic mil_irq_asserts #(.PC_W(PC_W)) chk_u (.*);
`default_nettype wire

// file: tb/tb_mil_irq_logic.sv
/* Self-checking bench for the interrupt block with a core model.
   Registers reached over AXI4-Lite; one 250 MHz clock. */
`timescale 1ns/1ps
`default_nettype none
module tb_mil_irq_logic
  import mil_pkg::*;
;
  // Names match the design ports so the instance binds by name
  logic CLK = 1'b0, RST = 1'b1, EDGE_IRQ_PIN = 1'b0, TIMER_ZERO_ROLLOVER = 1'b0;
  logic [3:0] SECOND_PORT_PINS = 4'h0, S_AXI_WSTRB = 4'hf;
  logic [7:0] PERIPH_EVT_A = 8'h00, PERIPH_EVT_B = 8'h00, S_AXI_AWADDR = 8'h00;
  logic [7:0] S_AXI_ARADDR = 8'h00;
  logic [31:0] S_AXI_WDATA = 32'h0, S_AXI_RDATA;
  logic S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_BREADY = 1'b0;
  logic S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0, do_sleep = 1'b0, do_ret = 1'b0;
  logic INSTR_BOUNDARY, SLEEP_INSTR, RETURN_FROM_IRQ_INSTR, IRQ_TAKE, STACK_PUSH, STACK_POP;
  logic CORE_WAKE, CORE_ASLEEP, S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY;
  logic S_AXI_RVALID, IRQ_OUT;
  logic [12:0] RETURN_PC, PUSH_PC, VECTOR_PC;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
  int n_mismatch = 0;
  int num_checks = 0;
  always #2 CLK = ~CLK;
  mil_irq_logic #(.PC_W(13)) dut_u (.*);
  mil_core_model core_u (.clk(CLK), .rst(RST), .do_sleep(do_sleep), .do_ret(do_ret),
    .take(IRQ_TAKE), .asleep(CORE_ASLEEP), .boundary(INSTR_BOUNDARY),
    .sleep_instr(SLEEP_INSTR), .ret_instr(RETURN_FROM_IRQ_INSTR), .ret_pc(RETURN_PC));
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      $display("[FAIL] %s expected %h seen %h", s, e, g);
      n_mismatch++;
    end
  endtask
  task automatic hang();
    n_mismatch++;
    results();
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge CLK);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge CLK);
    S_AXI_AWADDR <= a;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WDATA <= d;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge CLK);
      if (S_AXI_AWREADY)
        S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WREADY)
        S_AXI_WVALID <= 1'b0;
      if (S_AXI_BVALID)
        break;
    end
    if (n == 50)
      hang();
    S_AXI_BREADY <= 1'b0;
    chk($sformatf("bresp %h", a), 32'(er), 32'(S_AXI_BRESP));
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    int n;
    @(posedge CLK);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge CLK);
      if (S_AXI_ARREADY)
        S_AXI_ARVALID <= 1'b0;
      if (S_AXI_RVALID)
        break;
    end
    if (n == 50)
      hang();
    S_AXI_RREADY <= 1'b0;
    chk($sformatf("rdata %h", a), e, S_AXI_RDATA);
    chk($sformatf("rresp %h", a), 32'(er), 32'(S_AXI_RRESP));
  endtask
  task automatic pin(input logic v);
    @(posedge CLK);
    EDGE_IRQ_PIN <= v;
    cyc(3);
  endtask
  task automatic cmd(input logic s);
    @(posedge CLK);
    do_sleep <= s;
    do_ret <= !s;
    @(posedge CLK);
    do_sleep <= 1'b0;
    do_ret <= 1'b0;
  endtask
  task automatic wait_take(output int n);
    for (n = 1; n < 60; n++)
    begin
      @(posedge CLK);
      if (IRQ_TAKE === 1'b1)
        return;
    end
    hang();
  endtask
  task automatic quiet(input string s, input int c);
    int t = 0;
    repeat (c)
    begin
      @(posedge CLK);
      t += int'(IRQ_TAKE !== 1'b0);
    end
    chk(s, 0, t);
  endtask
  task automatic t_reset();
    rd(OFS_CONTROL, 32'h00, AXI_OKAY);
    rd(OFS_OPTION, 32'hff, AXI_OKAY);
    rd(8'h24, 32'h00, AXI_SLVERR);
    wr(8'h24, 32'hff, AXI_SLVERR);
    chk("irq_out", 0, IRQ_OUT);
  endtask
  task automatic t_flags();
    @(posedge CLK);
    EDGE_IRQ_PIN <= 1'b1;
    SECOND_PORT_PINS <= 4'h5;
    TIMER_ZERO_ROLLOVER <= 1'b1;
    PERIPH_EVT_A <= 8'h01;
    PERIPH_EVT_B <= 8'h80;
    @(posedge CLK);
    TIMER_ZERO_ROLLOVER <= 1'b0;
    PERIPH_EVT_A <= 8'h00;
    PERIPH_EVT_B <= 8'h00;
    cyc(3);
    rd(OFS_CONTROL, 32'h07, AXI_OKAY);
    rd(OFS_PFLAG_A, 32'h01, AXI_OKAY);
    rd(OFS_PFLAG_B, 32'h80, AXI_OKAY);
    wr(OFS_OPTION, 32'hbf, AXI_OKAY);
    wr(OFS_CONTROL, 32'h00, AXI_OKAY);
    pin(1'b0);
    rd(OFS_CONTROL, 32'h02, AXI_OKAY);
    wr(OFS_CONTROL, 32'h00, AXI_OKAY);
    pin(1'b1);
    rd(OFS_CONTROL, 32'h00, AXI_OKAY);
    wr(OFS_OPTION, 32'hff, AXI_OKAY);
  endtask
  task automatic t_take();
    int n;
    wr(OFS_PEN_A, 32'h01, AXI_OKAY);
    wr(OFS_CONTROL, 32'h80, AXI_OKAY);
    quiet("take without group", 20);
    wr(OFS_CONTROL, 32'hc0, AXI_OKAY);
    wait_take(n);
    chk("take delay", 1, n < 8);
    rd(OFS_CONTROL, 32'h40, AXI_OKAY);
    wr(OFS_PFLAG_A, 32'h00, AXI_OKAY);
    cmd(1'b0);
    rd(OFS_CONTROL, 32'hc0, AXI_OKAY);
    rd(OFS_EVT_STAT, 32'h05, AXI_OKAY);
    wr(OFS_EVT_MASK, 32'h01, AXI_OKAY);
    cyc(2);
    chk("irq_out", 1, IRQ_OUT);
    wr(OFS_EVT_STAT, 32'h01, AXI_OKAY);
    cyc(2);
    chk("irq_out", 0, IRQ_OUT);
    rd(OFS_EVT_STAT, 32'h04, AXI_OKAY);
  endtask
  task automatic t_lat();
    int n;
    wr(OFS_CONTROL, 32'h90, AXI_OKAY);
    pin(1'b0);
    EDGE_IRQ_PIN <= 1'b1;
    wait_take(n);
    // Count holds the sampling edge and the registered take
    chk("edge latency", 1, n >= 5 && n <= 6);
    wr(OFS_CONTROL, 32'h10, AXI_OKAY);
    cmd(1'b0);
    rd(OFS_CONTROL, 32'h90, AXI_OKAY);
  endtask
  task automatic t_sleep();
    int n;
    wr(OFS_CONTROL, 32'h10, AXI_OKAY);
    cmd(1'b1);
    // Sleep state is registered at the edge that ends the command
    cyc(1);
    chk("asleep", 1, CORE_ASLEEP);
    pin(1'b0);
    pin(1'b1);
    cyc(3);
    chk("awake", 0, CORE_ASLEEP);
    quiet("take after wake", 10);
    rd(OFS_CONTROL, 32'h12, AXI_OKAY);
    wr(OFS_CONTROL, 32'h90, AXI_OKAY);
    cmd(1'b1);
    pin(1'b0);
    EDGE_IRQ_PIN <= 1'b1;
    wait_take(n);
    chk("wake take", 1, n < 12);
  endtask
  initial
  begin
    cyc(20);
    RST <= 1'b0;
    t_reset();
    t_flags();
    t_take();
    t_lat();
    t_sleep();
    results();
  end
endmodule
`default_nettype wire
